// *** plsc_map.svh ***
`ifndef PLSC_MAP_SVH
`define PLSC_MAP_SVH

// Register byte offsets.
`define PLSC_CTRL_OFS 12'h000
`define PLSC_PCS_CTL_OFS 12'h004
`define PLSC_STATUS_OFS 12'h008
`define PLSC_ADVERT_OFS 12'h00c
`define PLSC_PARTNER_OFS 12'h010
`define PLSC_PCS_STS_OFS 12'h014

// Mode encodings of link_mode_select.
`define PLSC_MODE_SERDES 2'b11
`define PLSC_MODE_SGMII 2'b10
`define PLSC_MODE_KX 2'b01

// Speed encodings.
`define PLSC_SPEED_1000 2'b10

// Control register fields.
`define PLSC_CTRL_DUPLEX 0
`define PLSC_CTRL_LINK_UP 1
`define PLSC_CTRL_RX_PAUSE 2
`define PLSC_CTRL_TX_PAUSE 3
`define PLSC_CTRL_SPEED_LO 4
`define PLSC_CTRL_FRC_DPLX 6
`define PLSC_CTRL_FRC_SPD 7
`define PLSC_CTRL_MODE_LO 8

// PCS control fields.
`define PLSC_PCTL_AN_EN 0
`define PLSC_PCTL_FSD 1
`define PLSC_PCTL_PAUSE_OVR 2
`define PLSC_PCTL_FDV 3
`define PLSC_PCTL_FSV_LO 4

// Ability word fields.
`define PLSC_ABIL_FD 5
`define PLSC_ABIL_HD 6
`define PLSC_ABIL_PS1 7
`define PLSC_ABIL_PS2 8
`define PLSC_ABIL_SPD_LO 10

// Reset values.
`define PLSC_CTRL_RST 32'h0000_0320
`define PLSC_PCTL_RST 32'h0000_0020
`define PLSC_ADVERT_RST 16'h01a0

`endif

// *** plsc_pkg.sv ***
package plsc_pkg;

    // Settled link parameters.
    typedef struct packed {
        logic link_up;
        logic full_duplex;
        logic [1:0] speed;
        logic rx_pause;
        logic tx_pause;
        logic an_done;
    } plsc_link_t;

    // Raw PCS indications.
    typedef struct packed {
        logic autoneg_done;
        logic pcs_link_ok;
        logic comma_det;
        logic [1:0] sgmii_speed;
    } plsc_pcs_t;

endpackage : plsc_pkg

// *** plsc_resolve.sv ***
`timescale 1ns/100ps
`include "plsc_map.svh"

// Priority resolution of the local and partner ability words.
module plsc_resolve
    import plsc_pkg::*;
(
    // Ability words
    input wire logic [15:0] i_local,
    input wire logic [15:0] i_partner,
    // Resolution
    output logic o_full_duplex,
    output logic o_rx_pause,
    output logic o_tx_pause,
    output logic [1:0] o_speed
);
    logic lps1;
    logic lps2;
    logic pps1;
    logic pps2;

    always_comb begin
        lps1 = i_local[`PLSC_ABIL_PS1];
        lps2 = i_local[`PLSC_ABIL_PS2];
        pps1 = i_partner[`PLSC_ABIL_PS1];
        pps2 = i_partner[`PLSC_ABIL_PS2];
        // Full duplex wins over half when both ends offer it.
        o_full_duplex = i_local[`PLSC_ABIL_FD] & i_partner[`PLSC_ABIL_FD];
        // Standard symmetric and asymmetric pause table.
        o_tx_pause = (lps1 & pps1) | (~lps1 & lps2 & pps1 & pps2);
        o_rx_pause = (lps1 & pps1) | (lps1 & lps2 & ~pps1 & pps2);
        // Speed comes from the partner word, as an SGMII PHY reports it.
        o_speed = i_partner[`PLSC_ABIL_SPD_LO +: 2];
    end

endmodule : plsc_resolve

// *** plsc_top.sv ***
`timescale 1ns/100ps
`include "plsc_map.svh"

module plsc_top
    import plsc_pkg::*;
(
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // PCS indications, asynchronous to this clock
    input wire logic i_autoneg_done,
    input wire logic i_pcs_link_ok,
    input wire logic i_comma_det,
    input wire logic [1:0] i_sgmii_speed,
    // Settled link state
    output logic [1:0] o_link_mode_select,
    output logic o_link_up_status,
    output logic o_duplex_status,
    output logic [1:0] o_speed_status,
    output logic o_rx_pause_enable,
    output logic o_tx_pause_enable
);
    plsc_pcs_t pcs_s1_r;
    plsc_pcs_t pcs_s2_r;
    logic [31:0] ctrl_r;
    logic [31:0] ctrl_nxt;
    logic [31:0] pctl_r;
    logic [31:0] pctl_nxt;
    logic [15:0] advert_r;
    logic [15:0] advert_nxt;
    logic [15:0] partner_r;
    logic [15:0] partner_nxt;
    plsc_link_t link_r;
    plsc_link_t link_nxt;
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    logic pready_r;
    logic pready_nxt;
    logic pslverr_r;
    logic pslverr_nxt;
    logic res_fd;
    logic res_rx;
    logic res_tx;
    logic wr_en;
    logic rd_en;
    logic hit;
    logic [1:0] mode;
    logic an_en;
    logic slu;

    // Two stage synchroniser for the PCS indications.
    // The speed bits are assumed quasi-static; each bit is synchronised on its own.
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            pcs_s1_r <= '0;
            pcs_s2_r <= '0;
        end else begin
            pcs_s1_r <= {i_autoneg_done, i_pcs_link_ok, i_comma_det, i_sgmii_speed};
            pcs_s2_r <= pcs_s1_r;
        end
    end

    // The resolved speed is left open: in SGMII autoneg the speed comes from the in-band pins.
    plsc_resolve u_resolve (
        .i_local(advert_r),
        .i_partner(partner_r),
        .o_full_duplex(res_fd),
        .o_rx_pause(res_rx),
        .o_tx_pause(res_tx),
        .o_speed()
    );

    assign mode = ctrl_r[`PLSC_CTRL_MODE_LO +: 2];
    assign an_en = pctl_r[`PLSC_PCTL_AN_EN];
    assign slu = ctrl_r[`PLSC_CTRL_LINK_UP];

    // Access phase of APB; the slave answers with one wait state.
    assign wr_en = i_psel & i_penable & i_pwrite & ~pready_r;
    assign rd_en = i_psel & i_penable & ~i_pwrite & ~pready_r;

    always_comb begin
        hit = 1'b1;
        case (i_paddr)
            `PLSC_CTRL_OFS: prdata_nxt = ctrl_r;
            `PLSC_PCS_CTL_OFS: prdata_nxt = pctl_r;
            `PLSC_STATUS_OFS: prdata_nxt = {25'h0, link_r};
            `PLSC_ADVERT_OFS: prdata_nxt = {16'h0, advert_r};
            `PLSC_PARTNER_OFS: prdata_nxt = {16'h0, partner_r};
            `PLSC_PCS_STS_OFS: prdata_nxt = {27'h0, pcs_s2_r};
            default: begin
                prdata_nxt = 32'h0;
                hit = 1'b0;
            end
        endcase
        if (!rd_en) begin
            prdata_nxt = prdata_r;
        end
        pready_nxt = i_psel & i_penable & ~pready_r;
        pslverr_nxt = i_psel & i_penable & ~pready_r & ~hit;
    end

    // Register writes; hardware updates the pause enables in SerDes autoneg.
    always_comb begin
        ctrl_nxt = ctrl_r;
        pctl_nxt = pctl_r;
        advert_nxt = advert_r;
        partner_nxt = partner_r;
        if (wr_en) begin
            case (i_paddr)
                `PLSC_CTRL_OFS: ctrl_nxt = {22'h0, i_pwdata[9:0]};
                `PLSC_PCS_CTL_OFS: pctl_nxt = {26'h0, i_pwdata[5:0]};
                `PLSC_ADVERT_OFS: advert_nxt = i_pwdata[15:0];
                `PLSC_PARTNER_OFS: partner_nxt = i_pwdata[15:0];
                default: ;
            endcase
        end
        // The hardware write takes priority over a software write in the same cycle.
        if (mode == `PLSC_MODE_SERDES && an_en && !pctl_nxt[`PLSC_PCTL_PAUSE_OVR]) begin
            ctrl_nxt[`PLSC_CTRL_RX_PAUSE] = res_rx;
            ctrl_nxt[`PLSC_CTRL_TX_PAUSE] = res_tx;
        end
    end

    // Link status resolution per mode.
    always_comb begin
        link_nxt.an_done = pcs_s2_r.autoneg_done;
        link_nxt.rx_pause = ctrl_r[`PLSC_CTRL_RX_PAUSE];
        link_nxt.tx_pause = ctrl_r[`PLSC_CTRL_TX_PAUSE];
        link_nxt.full_duplex = ctrl_r[`PLSC_CTRL_DUPLEX];
        link_nxt.speed = `PLSC_SPEED_1000;
        link_nxt.link_up = 1'b0;
        case (mode)
            `PLSC_MODE_SERDES: begin
                if (an_en) begin
                    link_nxt.full_duplex = res_fd;
                    link_nxt.link_up = pcs_s2_r.autoneg_done;
                end else begin
                    link_nxt.link_up = pcs_s2_r.comma_det;
                end
            end
            `PLSC_MODE_SGMII: begin
                if (an_en) begin
                    link_nxt.full_duplex = res_fd;
                    link_nxt.speed = pcs_s2_r.sgmii_speed;
                    link_nxt.link_up = pcs_s2_r.pcs_link_ok;
                end else begin
                    link_nxt.speed = ctrl_r[`PLSC_CTRL_SPEED_LO +: 2];
                    link_nxt.link_up = pcs_s2_r.pcs_link_ok;
                end
            end
            `PLSC_MODE_KX: begin
                link_nxt.link_up = pcs_s2_r.comma_det;
            end
            // Mode 00 has no PCS link here, so link up stays low.
            default: begin
                link_nxt.speed = ctrl_r[`PLSC_CTRL_SPEED_LO +: 2];
            end
        endcase
        if (!slu) begin
            link_nxt.link_up = 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            ctrl_r <= `PLSC_CTRL_RST;
            pctl_r <= `PLSC_PCTL_RST;
            advert_r <= `PLSC_ADVERT_RST;
            partner_r <= 16'h0;
            link_r <= '0;
            prdata_r <= 32'h0;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            pctl_r <= pctl_nxt;
            advert_r <= advert_nxt;
            partner_r <= partner_nxt;
            link_r <= link_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    assign o_prdata = prdata_r;
    assign o_pready = pready_r;
    assign o_pslverr = pslverr_r;
    assign o_link_mode_select = ctrl_r[`PLSC_CTRL_MODE_LO +: 2];
    assign o_link_up_status = link_r.link_up;
    assign o_duplex_status = link_r.full_duplex;
    assign o_speed_status = link_r.speed;
    assign o_rx_pause_enable = ctrl_r[`PLSC_CTRL_RX_PAUSE];
    assign o_tx_pause_enable = ctrl_r[`PLSC_CTRL_TX_PAUSE];

endmodule : plsc_top

// *** plsc_top_sva.sv ***
`timescale 1ns/100ps
module plsc_top_chk (
    // Clock
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // APB
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic o_pready,
    // PCS
    input wire logic i_autoneg_done,
    input wire logic i_pcs_link_ok,
    input wire logic i_comma_det,
    input wire logic [1:0] i_sgmii_speed,
    // Status
    input wire logic [1:0] o_link_mode_select,
    input wire logic o_link_up_status,
    input wire logic o_duplex_status,
    input wire logic [1:0] o_speed_status,
    input wire logic o_rx_pause_enable,
    input wire logic o_tx_pause_enable
);
    // Shadow of control and PCS control; the top bits count quiet cycles since a change.
    logic [14:0] sh_r, sh_nxt;
    logic wr, fx, ok;
    assign wr = i_psel && i_penable && !o_pready && i_pwrite;
    assign fx = sh_r[9:8] == 2'h3 || sh_r[9:8] == 2'h1;
    assign ok = sh_r[14];
    always_comb begin
        sh_nxt = sh_r;
        if (wr && i_paddr == 12'h000) sh_nxt[9:0] = i_pwdata[9:0];
        if (wr && i_paddr == 12'h004) sh_nxt[12:10] = i_pwdata[2:0];
        if (sh_nxt[12:0] != sh_r[12:0]) sh_nxt[14:13] = 2'h0;
        else if (sh_r[14:13] != 2'h3) sh_nxt[14:13] = sh_r[14:13] + 2'h1;
    end
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) sh_r <= 15'h0320;
        else sh_r <= sh_nxt;
    end
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    AST_MODE: assert property (o_link_mode_select == sh_r[9:8])
        else $error("mode mismatch");
    AST_SPEED: assert property (ok && fx |-> o_speed_status == 2'h2)
        else $error("speed not 1000");
    AST_DUP_FRC: assert property (ok && fx && !sh_r[10] |-> o_duplex_status == sh_r[0])
        else $error("forced duplex mismatch");
    AST_LU_OFF: assert property (ok && !sh_r[1] |-> !o_link_up_status)
        else $error("link up while disabled");
    AST_LU_FRC: assert property (ok && fx && !sh_r[10] && o_link_up_status
        |-> $past(i_comma_det, 3)) else $error("link up without comma");
    AST_LU_AN: assert property (ok && sh_r[9:8] == 2'h3 && sh_r[10]
        |-> o_link_up_status == ($past(i_autoneg_done, 3) && sh_r[1]))
        else $error("link up not from autoneg");
    AST_SGMII: assert property (ok && sh_r[9:8] == 2'h2 && sh_r[10]
        |-> o_link_up_status == ($past(i_pcs_link_ok, 3) && sh_r[1])
        && (!o_link_up_status || o_speed_status == $past(i_sgmii_speed, 3)))
        else $error("sgmii link or speed mismatch");
    AST_PAUSE_HOLD: assert property (ok && sh_r[9:8] == 2'h3 && sh_r[10] && sh_r[12]
        |-> $stable({o_rx_pause_enable, o_tx_pause_enable})) else $error("pause moved");
endmodule : plsc_top_chk

// *** plsc_pcs_model.sv ***
`timescale 1ns/100ps
// Negotiation completes after a short or a long lag, so both kinds of answer are seen.
module plsc_pcs_model
    import plsc_pkg::*;
(
    // Control
    input wire logic i_clk_sys,
    input wire logic i_up,
    input wire logic i_slow,
    input wire logic [1:0] i_spd,
    // PCS indications
    output plsc_pcs_t o_pcs
);
    int cnt = 0;
    initial o_pcs = '0;
    always @(posedge i_clk_sys) begin
        cnt <= i_up ? cnt + 1 : 0;
        o_pcs.comma_det <= i_up;
        o_pcs.autoneg_done <= i_up && cnt > (i_slow ? 20 : 2);
        o_pcs.pcs_link_ok <= i_up && cnt > (i_slow ? 20 : 2);
        // A dropped in-band speed carries no value, so it keeps changing.
        o_pcs.sgmii_speed <= i_up ? i_spd : ~o_pcs.sgmii_speed;
    end
endmodule : plsc_pcs_model

// *** pcs_link_setup_control_tb.sv ***
`timescale 1ns/100ps
module pcs_link_setup_control_tb;
    import plsc_pkg::*;
    logic i_clk_sys = 1'b0;
    logic i_rst = 1'b1;
    logic i_psel = 1'b0;
    logic i_penable = 1'b0;
    logic i_pwrite = 1'b0;
    logic [11:0] i_paddr = 12'h000;
    logic [31:0] i_pwdata = 32'h0, o_prdata, rq;
    logic o_pready, o_pslverr, rerr, up = 1'b0, slow = 1'b0;
    logic o_link_up_status, o_duplex_status, o_rx_pause_enable, o_tx_pause_enable;
    logic [1:0] o_link_mode_select, o_speed_status, spd = 2'h0;
    plsc_pcs_t pcs;
    int n_mismatch = 0;
    int compares = 0;
    always #5 i_clk_sys = ~i_clk_sys;
    plsc_pcs_model pm (.i_clk_sys, .i_up(up), .i_slow(slow), .i_spd(spd), .o_pcs(pcs));
    plsc_top dut (.i_clk_sys, .i_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
        .o_prdata, .o_pready, .o_pslverr, .i_autoneg_done(pcs.autoneg_done),
        .i_pcs_link_ok(pcs.pcs_link_ok), .i_comma_det(pcs.comma_det),
        .i_sgmii_speed(pcs.sgmii_speed), .o_link_mode_select, .o_link_up_status,
        .o_duplex_status, .o_speed_status, .o_rx_pause_enable, .o_tx_pause_enable);
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        compares++;
        if (s !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        i_psel <= 1'b1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_clk_sys);
        i_penable <= 1'b1;
        // The request stands until pready is seen high; only the watchdog ends a hang.
        do begin
            @(posedge i_clk_sys);
        end while (o_pready !== 1'b1);
        rq = o_prdata;
        rerr = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
        @(posedge i_clk_sys);
        chk("pready pulse", 32'h0, {31'h0, o_pready});
    endtask : apb
    task automatic wt(input int n);
        repeat (n) @(posedge i_clk_sys);
    endtask : wt
    task automatic sc(input string nm, input logic [5:0] e);
        chk(nm, {26'h0, e}, {26'h0, o_link_up_status, o_duplex_status, o_speed_status,
            o_rx_pause_enable, o_tx_pause_enable});
    endtask : sc
    task automatic t_regs;
        apb(1'b0, 12'h000, 32'h0);
        chk("ctrl", 32'h320, rq);
        apb(1'b0, 12'h004, 32'h0);
        chk("pcs ctl", 32'h20, rq);
        apb(1'b0, 12'h00c, 32'h0);
        chk("advert", 32'h1a0, rq);
        apb(1'b0, 12'h018, 32'h0);
        chk("unmapped", 32'h1, {31'h0, rerr});
        chk("mode", 32'h3, {30'h0, o_link_mode_select});
    endtask : t_regs
    task automatic t_serdes_an;
        apb(1'b1, 12'h000, 32'h302);
        apb(1'b1, 12'h004, 32'h021);
        apb(1'b1, 12'h010, 32'h1a0);
        slow <= 1'b1;
        up <= 1'b1;
        wt(8);
        chk("an pending", 32'h0, {31'h0, o_link_up_status});
        wt(30);
        sc("an done", 6'h3b);
        apb(1'b1, 12'h010, 32'h020);
        wt(6);
        sc("no pause", 6'h38);
        apb(1'b1, 12'h004, 32'h025);
        apb(1'b1, 12'h010, 32'h1a0);
        wt(6);
        sc("override", 6'h38);
        apb(1'b1, 12'h000, 32'h30e);
        wt(2);
        sc("sw pause", 6'h3b);
        apb(1'b0, 12'h008, 32'h0);
        chk("status", 32'h77, rq);
        up <= 1'b0;
        slow <= 1'b0;
    endtask : t_serdes_an
    task automatic t_forced;
        for (int m = 1; m < 4; m += 2) begin
            apb(1'b1, 12'h000, {22'h0, m[1:0], 8'he3});
            apb(1'b1, 12'h004, 32'h02e);
            up <= 1'b0;
            wt(6);
            sc("no comma", 6'h18);
            up <= 1'b1;
            wt(6);
            sc("comma", 6'h38);
            apb(1'b1, 12'h000, {22'h0, m[1:0], 8'hd0});
            wt(4);
            sc("slu off", 6'h08);
        end
    endtask : t_forced
    task automatic t_sgmii;
        apb(1'b1, 12'h000, 32'h202);
        apb(1'b1, 12'h004, 32'h021);
        spd <= 2'h1;
        wt(10);
        sc("sgmii", 6'h34);
        apb(1'b1, 12'h004, 32'h02d);
        apb(1'b1, 12'h000, 32'h232);
        wt(4);
        sc("forcing ignored", 6'h34);
        spd <= 2'h2;
        wt(6);
        sc("sgmii 1000", 6'h38);
        up <= 1'b0;
        wt(6);
        chk("sgmii down", 32'h0, {31'h0, o_link_up_status});
    endtask : t_sgmii
    task automatic t_modes;
        apb(1'b1, 12'h004, 32'h000);
        apb(1'b1, 12'h000, 32'h212);
        up <= 1'b1;
        wt(10);
        sc("sgmii forced", 6'h24);
        apb(1'b1, 12'h000, 32'h012);
        wt(2);
        sc("mode 00", 6'h04);
    endtask : t_modes
    task automatic t_reset;
        i_rst <= 1'b1;
        wt(2);
        sc("in reset", 6'h00);
        chk("reset mode", 32'h3, {30'h0, o_link_mode_select});
        i_rst <= 1'b0;
        wt(2);
        sc("after reset", 6'h08);
        apb(1'b0, 12'h000, 32'h0);
        chk("ctrl after reset", 32'h320, rq);
    endtask : t_reset
    task automatic results;
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : results
    initial begin
        wt(10);
        i_rst <= 1'b0;
        wt(1);
        t_regs;
        t_serdes_an;
        t_forced;
        t_sgmii;
        t_modes;
        t_reset;
        results;
    end
    initial begin
        #50us;
        n_mismatch++;
        results;
    end
endmodule : pcs_link_setup_control_tb
bind plsc_top plsc_top_chk chk_i (.i_clk_sys, .i_rst, .i_psel, .i_penable, .i_pwrite,
    .i_paddr, .i_pwdata, .o_pready, .i_autoneg_done, .i_pcs_link_ok, .i_comma_det,
    .i_sgmii_speed, .o_link_mode_select, .o_link_up_status, .o_duplex_status,
    .o_speed_status, .o_rx_pause_enable, .o_tx_pause_enable);
